// >>> shared/rdt_defines.svh
`ifndef RDT_DEFINES_SVH
`define RDT_DEFINES_SVH

// Register indexes, byte address is index times four
`define RDT_IDX_R1_VAL 8'h25
`define RDT_IDX_LOC_VAL 8'h26
`define RDT_IDX_R2_VAL 8'h27
`define RDT_IDX_STS 8'h40
`define RDT_IDX_MSK 8'h41
`define RDT_IDX_R1_OFS 8'h70
`define RDT_IDX_R2_OFS 8'h72
`define RDT_IDX_FRAC 8'h77
`define RDT_IDX_CFG5 8'h7C

// Reset values
`define RDT_RST_OFS 8'h00
`define RDT_RST_CFG5 8'h00
`define RDT_RST_MSK 4'h0
`define RDT_RST_RES 10'h000

// Field positions
`define RDT_CFG5_TWOS 1
`define RDT_STS_FAULT 3

// Channels and diode current codes
`define RDT_CH_R1 2'h0
`define RDT_CH_LOC 2'h1
`define RDT_CH_R2 2'h2
`define RDT_CUR_BASE 2'h0
`define RDT_CUR_N1 2'h1
`define RDT_CUR_N2 2'h2

// Last sample index of an average, then result codes in quarter-degree units
`define RDT_AVG_LAST 4'hF
`define RDT_EXT_MIN 13'sh0004
`define RDT_EXT_MAX 13'sh03FF
`define RDT_TWOS_BIAS 13'sh0100
`define RDT_TWOS_MIN 13'sh1F04
`define RDT_TWOS_MAX 13'sh01FC
`define RDT_FLT_EXT 10'h000
`define RDT_FLT_TWOS 10'h200

// Diode current settling time
`define RDT_CLK_MHZ 200
`define RDT_SETTLE_NS 2000
`define RDT_SETTLE_CYC ((`RDT_SETTLE_NS * `RDT_CLK_MHZ + 999) / 1000)

`endif

// >>> shared/rdt_pkg.sv
package rdt_pkg;
   // Measurement sequencer states
   typedef enum logic [1:0] {
      RDT_ST_SETTLE,
      RDT_ST_START,
      RDT_ST_WAIT
   } rdt_state_t;
endpackage

// >>> verilog/rdt_result.sv
`timescale 1ns/100ps
`include "rdt_defines.svh"
module rdt_result (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic smp_vld_i,
   input wire logic [9:0] smp_i,
   input wire logic flt_i,
   input wire logic [7:0] ofs_i,
   input wire logic twos_i,
   output logic [9:0] res_o,
   output logic res_vld_o,
   output logic flt_o
);
   logic [13:0] sum_r;
   logic [3:0] cnt_r;
   logic flt_r;
   logic [13:0] full;
   logic signed [12:0] corr;
   logic signed [12:0] tc;
   logic [9:0] res_nxt;

   // Sixteen-sample accumulation
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sum_r <= 14'h0000;
         cnt_r <= 4'h0;
         flt_r <= 1'b0;
      end
      else if (smp_vld_i)
      begin
         cnt_r <= cnt_r + 4'h1;
         sum_r <= (cnt_r == `RDT_AVG_LAST) ? 14'h0000 : full; // [R4]
         flt_r <= (cnt_r == `RDT_AVG_LAST) ? 1'b0 : (flt_r | flt_i);
      end
   end

   // Average, offset, clamp and format
   always_comb
   begin
      full = sum_r + {4'h0, smp_i};
      corr = $signed({3'b000, full[13:4]}) + $signed({{4{ofs_i[7]}}, ofs_i, 1'b0}); // [R6] [R7]
      if (corr < `RDT_EXT_MIN)
         corr = `RDT_EXT_MIN; // [R12]
      else if (corr > `RDT_EXT_MAX)
         corr = `RDT_EXT_MAX;
      tc = corr - `RDT_TWOS_BIAS;
      if (tc < `RDT_TWOS_MIN)
         tc = `RDT_TWOS_MIN; // [R11]
      else if (tc > `RDT_TWOS_MAX)
         tc = `RDT_TWOS_MAX; // [R1]
      if (flt_r | flt_i)
         res_nxt = twos_i ? `RDT_FLT_TWOS : `RDT_FLT_EXT; // [R1] [R2] [R12]
      else if (twos_i)
         res_nxt = tc[9:0]; // [R1]
      else
         res_nxt = corr[9:0]; // [R2]
   end

   // Result register, loaded after the sixteenth sample
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         res_o <= `RDT_RST_RES;
         res_vld_o <= 1'b0;
         flt_o <= 1'b0;
      end
      else
      begin
         res_vld_o <= smp_vld_i && (cnt_r == `RDT_AVG_LAST); // [R4]
         if (smp_vld_i && (cnt_r == `RDT_AVG_LAST))
         begin
            res_o <= res_nxt;
            flt_o <= flt_r | flt_i;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_fault_code;
      res_vld_o && flt_o |-> res_o == ($past(twos_i) ? `RDT_FLT_TWOS : `RDT_FLT_EXT);
   endproperty
   a_fault_code: assert property (p_fault_code) else $error("bad fault code"); // [R12]

   property p_twos_range;
      res_vld_o && !flt_o && $past(twos_i) |->
         $signed(res_o) >= -10'sd252 && $signed(res_o) <= 10'sd508;
   endproperty
   a_twos_range: assert property (p_twos_range) else $error("twos result out of range"); // [R11]

   property p_ext_nofault;
      res_vld_o && !flt_o && !$past(twos_i) |-> res_o >= 10'h004;
   endproperty
   a_ext_nofault: assert property (p_ext_nofault) else $error("ext result hits fault code"); // [R2]

   property p_sixteen;
      res_vld_o |-> $past(cnt_r) == `RDT_AVG_LAST && $past(smp_vld_i);
   endproperty
   a_sixteen: assert property (p_sixteen) else $error("result not after 16 samples"); // [R4]

   c_fault: cover property (res_vld_o && flt_o);
endmodule

// >>> verilog/rdt_core.sv
`timescale 1ns/100ps
`include "rdt_defines.svh"
// What this block does
// R1 - Twos format codes 0.25 degree steps, tops at +127 and uses -128 for a diode fault.
// R2 - Extended format is offset by 64 degrees with the all-zero code meaning diode fault.
// R3 - Value registers hold the upper eight result bits, the fraction register the low two.
// R4 - Each stored result is the average of 16 consecutive measurement cycles.
// R5 - Remote diode current toggles base/first multiple, then base/second multiple.
// R6 - The signed offset register of each remote channel is added to its results.
// R7 - One offset step is worth half a degree.
// R8 - Software writes the algebraic sum of all corrections as one offset.
// R9 - Reading the fraction register freezes value registers until all are read.
// R10 - Fraction register holds remote 2, local, then remote 1 bit pairs from the top.
// R11 - A config bit selects twos storage, computed in extended range and clamped.
// R12 - Offset is added after averaging, saturated, and a fault code bypasses it.
module rdt_core (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   output logic [1:0] diode_cur_sel_o,
   output logic [1:0] diode_chan_o,
   output logic adc_start_o,
   input wire logic adc_done_i,
   input wire logic [9:0] adc_data_i,
   input wire logic diode_fault_i
);
   logic [7:0] ofs1_r;
   logic [7:0] ofs2_r;
   logic [7:0] cfg5_r;
   logic [3:0] msk_r;
   logic [3:0] sts_r;
   logic [9:0] pend_r [3];
   logic [9:0] vis_r [3];
   logic frozen_r;
   logic [2:0] seen_r;
   rdt_pkg::rdt_state_t st_r;
   logic [1:0] step_r;
   logic [11:0] tmr_r;
   logic [3:0] mcnt_r;
   logic [9:0] d1_r;
   logic smp_vld_r;
   logic [1:0] smp_ch_r;
   logic [9:0] smp_r;
   logic smp_flt_r;
   logic [2:0] res_vld;
   logic [2:0] res_flt;
   logic acc;
   logic wr;
   logic rd;
   logic [7:0] idx;
   logic [7:0] frac;
   logic [31:0] rd_nxt;
   logic signed [11:0] comb;
   logic remote;
   logic [3:0] sts_set;

   // Bus decode
   assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0]; // Lands at the ack edge
   assign rd = acc & ~wb_we_i;
   assign idx = wb_adr_i[9:2];
   assign frac = {vis_r[2][1:0], vis_r[1][1:0], vis_r[0][1:0], 2'b00}; // [R10]
   assign remote = diode_chan_o != `RDT_CH_LOC;

   // Series-resistance cancelling combination of both readings
   assign comb = $signed({1'b0, d1_r, 1'b0}) - $signed({2'b00, adc_data_i}); // [R5]

   // Read data mux, unmapped reads as zero
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      case (idx)
         `RDT_IDX_R1_VAL: rd_nxt[7:0] = vis_r[0][9:2]; // [R3]
         `RDT_IDX_LOC_VAL: rd_nxt[7:0] = vis_r[1][9:2];
         `RDT_IDX_R2_VAL: rd_nxt[7:0] = vis_r[2][9:2];
         `RDT_IDX_FRAC: rd_nxt[7:0] = frac; // [R3]
         `RDT_IDX_R1_OFS: rd_nxt[7:0] = ofs1_r;
         `RDT_IDX_R2_OFS: rd_nxt[7:0] = ofs2_r;
         `RDT_IDX_CFG5: rd_nxt[7:0] = cfg5_r;
         `RDT_IDX_STS: rd_nxt[3:0] = sts_r;
         `RDT_IDX_MSK: rd_nxt[3:0] = msk_r;
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // Bus acknowledge and read data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= acc;
         if (rd)
            wb_dat_o <= rd_nxt;
      end
   end

   // Writable registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ofs1_r <= `RDT_RST_OFS;
         ofs2_r <= `RDT_RST_OFS;
         cfg5_r <= `RDT_RST_CFG5;
         msk_r <= `RDT_RST_MSK;
      end
      else if (wr)
      begin
         if (idx == `RDT_IDX_R1_OFS)
            ofs1_r <= wb_dat_i[7:0]; // [R6] [R8]
         if (idx == `RDT_IDX_R2_OFS)
            ofs2_r <= wb_dat_i[7:0]; // [R6] [R8]
         if (idx == `RDT_IDX_CFG5)
            cfg5_r <= wb_dat_i[7:0]; // [R11]
         if (idx == `RDT_IDX_MSK)
            msk_r <= wb_dat_i[3:0];
      end
   end

   // Freeze on fraction read, thaw after all value reads
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         frozen_r <= 1'b0;
         seen_r <= 3'b000;
      end
      else if (rd && idx == `RDT_IDX_FRAC)
      begin
         frozen_r <= 1'b1; // [R9]
         seen_r <= 3'b000;
      end
      else if (frozen_r && rd)
      begin
         if ((seen_r | {idx == `RDT_IDX_R2_VAL, idx == `RDT_IDX_LOC_VAL,
                        idx == `RDT_IDX_R1_VAL}) == 3'b111)
         begin
            frozen_r <= 1'b0; // [R9]
            seen_r <= 3'b000;
         end
         else
            seen_r <= seen_r | {idx == `RDT_IDX_R2_VAL, idx == `RDT_IDX_LOC_VAL,
                                idx == `RDT_IDX_R1_VAL};
      end
   end

   // Measurement sequencer driving diode current and converter
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r <= rdt_pkg::RDT_ST_SETTLE;
         step_r <= 2'h0;
         tmr_r <= 12'(`RDT_SETTLE_CYC - 1);
         mcnt_r <= 4'h0;
         d1_r <= 10'h000;
         diode_chan_o <= `RDT_CH_R1;
         diode_cur_sel_o <= `RDT_CUR_BASE;
         adc_start_o <= 1'b0;
         smp_vld_r <= 1'b0;
         smp_ch_r <= `RDT_CH_R1;
         smp_r <= 10'h000;
         smp_flt_r <= 1'b0;
      end
      else
      begin
         smp_vld_r <= 1'b0;
         adc_start_o <= 1'b0;
         unique case (st_r)
            rdt_pkg::RDT_ST_SETTLE:
            begin
               if (tmr_r != 12'h000)
                  tmr_r <= tmr_r - 12'h001;
               else if (!remote || step_r[0])
                  st_r <= rdt_pkg::RDT_ST_START;
               else
               begin
                  // Base current settled, switch to the multiple
                  step_r <= step_r + 2'h1;
                  diode_cur_sel_o <= step_r[1] ? `RDT_CUR_N2 : `RDT_CUR_N1; // [R5]
                  tmr_r <= 12'(`RDT_SETTLE_CYC - 1);
               end
            end
            rdt_pkg::RDT_ST_START:
            begin
               adc_start_o <= 1'b1;
               st_r <= rdt_pkg::RDT_ST_WAIT;
            end
            rdt_pkg::RDT_ST_WAIT:
            begin
               if (adc_done_i)
               begin
                  st_r <= rdt_pkg::RDT_ST_SETTLE;
                  tmr_r <= 12'(`RDT_SETTLE_CYC - 1);
                  diode_cur_sel_o <= `RDT_CUR_BASE; // [R5]
                  if (remote && step_r == 2'h1)
                  begin
                     d1_r <= adc_data_i; // [R5]
                     step_r <= 2'h2;
                  end
                  else
                  begin
                     smp_vld_r <= 1'b1;
                     smp_ch_r <= diode_chan_o;
                     smp_flt_r <= diode_fault_i;
                     if (!remote)
                        smp_r <= adc_data_i;
                     else if (comb < 12'sd0)
                        smp_r <= 10'h000;
                     else if (comb > 12'sd1023)
                        smp_r <= 10'h3FF;
                     else
                        smp_r <= comb[9:0]; // [R5]
                     step_r <= 2'h0;
                     mcnt_r <= mcnt_r + 4'h1;
                     if (mcnt_r == `RDT_AVG_LAST) // [R4]
                        diode_chan_o <= (diode_chan_o == `RDT_CH_R2) ? `RDT_CH_R1
                                        : diode_chan_o + 2'h1;
                  end
               end
            end
         endcase
      end
   end

   // Per-channel averaging, offset and result storage
   for (genvar g = 0; g < 3; g++)
   begin : g_ch
      logic [7:0] ofs;
      logic [9:0] res;
      assign ofs = (g == 0) ? ofs1_r : ((g == 2) ? ofs2_r : 8'h00);
      rdt_result u_res (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .smp_vld_i(smp_vld_r && smp_ch_r == 2'(g)),
         .smp_i(smp_r),
         .flt_i(smp_flt_r),
         .ofs_i(ofs),
         .twos_i(cfg5_r[`RDT_CFG5_TWOS]),
         .res_o(res),
         .res_vld_o(res_vld[g]),
         .flt_o(res_flt[g])
      );
      // Latest result, copied to the visible register when not frozen
      always_ff @(posedge clk_i)
      begin
         if (rst_i)
         begin
            pend_r[g] <= `RDT_RST_RES;
            vis_r[g] <= `RDT_RST_RES;
         end
         else
         begin
            if (res_vld[g])
               pend_r[g] <= res;
            // Hold already at the fraction read so fraction and value bits match
            if (!frozen_r && !(rd && idx == `RDT_IDX_FRAC))
               vis_r[g] <= pend_r[g]; // [R9]
         end
      end
   end

   // Sticky status, set wins over write-one-clear
   assign sts_set = {|(res_vld & res_flt), res_vld};
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sts_r <= 4'h0;
         irq_o <= 1'b0;
      end
      else
      begin
         if (wr && idx == `RDT_IDX_STS)
            sts_r <= (sts_r & ~wb_dat_i[3:0]) | sts_set;
         else
            sts_r <= sts_r | sts_set;
         irq_o <= |(sts_r & msk_r);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_cur_conv;
      adc_start_o && remote |-> diode_cur_sel_o == `RDT_CUR_N1 || diode_cur_sel_o == `RDT_CUR_N2;
   endproperty
   a_cur_conv: assert property (p_cur_conv) else $error("remote convert at base current"); // [R5]

   property p_cur_back;
      st_r == rdt_pkg::RDT_ST_WAIT && adc_done_i |=> diode_cur_sel_o == `RDT_CUR_BASE;
   endproperty
   a_cur_back: assert property (p_cur_back) else $error("current not back to base"); // [R5]

   property p_frozen_hold;
      frozen_r |=> $stable(vis_r[0]) && $stable(vis_r[1]) && $stable(vis_r[2]);
   endproperty
   a_frozen_hold: assert property (p_frozen_hold) else $error("value changed while frozen"); // [R9]

   property p_freeze_set;
      rd && idx == `RDT_IDX_FRAC |=> frozen_r ##1 wb_ack_o == 1'b0 || frozen_r;
   endproperty
   a_freeze_set: assert property (p_freeze_set) else $error("fraction read did not freeze"); // [R9]

   property p_frac_read;
      rd && idx == `RDT_IDX_FRAC |=> wb_ack_o && wb_dat_o[7:0] == $past(frac);
   endproperty
   a_frac_read: assert property (p_frac_read) else $error("fraction read data wrong"); // [R10]

   property p_val_read;
      rd && idx == `RDT_IDX_R2_VAL |=> wb_dat_o == {24'h000000, $past(vis_r[2][9:2])};
   endproperty
   a_val_read: assert property (p_val_read) else $error("value read data wrong"); // [R3]

   property p_irq;
      |(sts_r & msk_r) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised"); // [R4]

   property p_sts_set;
      res_vld[0] |=> sts_r[0];
   endproperty
   a_sts_set: assert property (p_sts_set) else $error("result event lost"); // [R4]

   c_thaw: cover property (frozen_r ##1 !frozen_r);
   c_twos: cover property (res_vld[2] && cfg5_r[`RDT_CFG5_TWOS]);
   c_ofs: cover property (res_vld[0] && ofs1_r[7]);
endmodule

// >>> verification/rdt_diode_model.sv
`timescale 1ns/100ps
`include "rdt_defines.svh"
module rdt_diode_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] cur_i,
   input wire logic start_i,
   input wire logic [3:0] noise_i,
   input wire logic [9:0] d1_i,
   input wire logic [9:0] d2_i,
   input wire logic [9:0] loc_i,
   input wire logic flt_i,
   output logic done_o,
   output logic [9:0] data_o,
   output logic fault_o
);
   logic [9:0] val_r;
   logic [4:0] dly_r;
   logic busy_r;
   logic fire;
   assign fire = busy_r && dly_r == 5'h01;
   // Latch reading for the applied multiple, answer after 1 to 31 cycles
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         busy_r <= 1'b0;
      else if (start_i)
      begin
         busy_r <= 1'b1;
         dly_r <= {noise_i, 1'b1};
         val_r <= ((cur_i == `RDT_CUR_N1) ? d1_i : (cur_i == `RDT_CUR_N2) ? d2_i : loc_i)
            + {6'h00, noise_i};
      end
      else if (busy_r)
      begin
         dly_r <= dly_r - 5'h01;
         busy_r <= !fire;
      end
   end
   // Done pulse; data and fault lines keep changing outside it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         done_o <= 1'b0;
         data_o <= 10'h155;
         fault_o <= 1'b0;
      end
      else
      begin
         done_o <= fire;
         data_o <= fire ? val_r : ~data_o;
         fault_o <= fire ? flt_i : ~fault_o;
      end
   end
endmodule

// >>> verification/test_remote_diode_temp_result_path.sv
`timescale 1ns/100ps
`include "rdt_defines.svh"
module test_remote_diode_temp_result_path;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, flt = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h0, noise = 4'h0;
   logic [31:0] dat = 32'h00000000, rdat, wdo;
   logic ack, irq, start, done, fault;
   logic [1:0] cur, chn;
   logic [9:0] adata, d1, d1b = 10'h190, d2b = 10'h1F4, lb = 10'h190;
   logic [9:0] ev [3] = '{default: 10'h000};
   logic [9:0] sv [3];
   logic [7:0] rl [8] = '{`RDT_IDX_R1_OFS, `RDT_IDX_R2_OFS, `RDT_IDX_FRAC, `RDT_IDX_CFG5,
      `RDT_IDX_STS, `RDT_IDX_MSK, `RDT_IDX_R1_VAL, 8'hFF};
   int errors = 0, checks = 0, rcnt = 0, ch = 0, k = 0, n = 0, sum = 0, o1 = 0, o2 = 0, s;
   bit tw = 0, fa = 0;

   rdt_core dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
      .irq_o(irq), .diode_cur_sel_o(cur), .diode_chan_o(chn), .adc_start_o(start),
      .adc_done_i(done), .adc_data_i(adata), .diode_fault_i(fault));
   rdt_diode_model model_u (
      .clk_i(clk_i), .rst_i(rst_i), .cur_i(cur), .start_i(start), .noise_i(noise),
      .d1_i(d1b), .d2_i(d2b), .loc_i(lb), .flt_i(flt), .done_o(done), .data_o(adata),
      .fault_o(fault));

   // Clock
   always #2.5 clk_i = ~clk_i;

   // Expected stored code from average, offset and format
   function automatic logic [9:0] fmt(int sm, bit f, int o);
      int e;
      if (f)
         return tw ? 10'h200 : 10'h000;
      e = (sm >>> 4) + 2 * o;
      e = (e < 4) ? 4 : (e > 1023) ? 1023 : e;
      if (tw)
         e = (e - 256 < -252) ? -252 : (e - 256 > 508) ? 508 : e - 256;
      return e[9:0];
   endfunction

   // Reference model: each channel in turn from remote 1, 16 samples each
   always @(posedge clk_i)
   begin
      if (!rst_i && done === 1'b1)
      begin
         fa = fa | fault;
         chk(chn, ch);
         chk(cur, (ch == 1) ? `RDT_CUR_BASE : (k == 0) ? `RDT_CUR_N1 : `RDT_CUR_N2);
         if (ch != 1 && k == 0)
         begin
            d1 = adata;
            k = 1;
         end
         else
         begin
            s = (ch == 1) ? int'(adata) : 2 * int'(d1) - int'(adata);
            s = (s < 0) ? 0 : (s > 1023) ? 1023 : s;
            sum += s;
            k = 0;
            n++;
            if (n == 16)
            begin
               ev[ch] = fmt(sum, fa, (ch == 0) ? o1 : (ch == 2) ? o2 : 0);
               ch = (ch + 1) % 3;
               n = 0;
               sum = 0;
               fa = 0;
               rcnt++;
            end
         end
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One classic bus cycle, data taken at the ack edge
   task wb(input bit w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] bs);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dat <= {24'h000000, d};
      sel <= bs;
      @(posedge clk_i);
      while (ack !== 1'b1)
         @(posedge clk_i);
      rdat = wdo;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task rc(input logic [7:0] idx, input logic [7:0] e);
      wb(1'b0, idx, 8'h00, 4'hF);
      chk(rdat, {24'h000000, e});
   endtask

   task wr(input logic [7:0] idx, input logic [7:0] d);
      wb(1'b1, idx, d, 4'h1);
   endtask

   task vals(input logic [9:0] a [3]);
      rc(`RDT_IDX_R1_VAL, a[0][9:2]);
      rc(`RDT_IDX_LOC_VAL, a[1][9:2]);
      rc(`RDT_IDX_R2_VAL, a[2][9:2]);
   endtask

   task frac;
      rc(`RDT_IDX_FRAC, {ev[2][1:0], ev[1][1:0], ev[0][1:0], 2'b00});
   endtask

   // Check selected status bits, then clear them all
   task stat(input logic [7:0] m, input logic [7:0] e);
      wb(1'b0, `RDT_IDX_STS, 8'h00, 4'hF);
      chk(rdat & {24'h000000, m}, {24'h000000, e});
      wr(`RDT_IDX_STS, 8'h0F);
   endtask

   task wres(input int c);
      while (rcnt < c)
         @(posedge clk_i);
      repeat (6) @(posedge clk_i);
   endtask

   task test_done;
      $display("comparisons %0d mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      repeat (95000) @(posedge clk_i);
      errors++;
      test_done;
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'hC302EC50));
      fork
         forever
         begin
            @(posedge clk_i);
            noise <= $urandom;
         end
      join_none
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++)
         rc(rl[i], 8'h00);
      wr(`RDT_IDX_FRAC, 8'hFF);
      rc(`RDT_IDX_FRAC, 8'h00);
      wr(8'hFF, 8'hFF);
      rc(8'hFF, 8'h00);
      wb(1'b1, `RDT_IDX_R2_OFS, 8'hFF, 4'h0);
      rc(`RDT_IDX_R2_OFS, 8'h00);
      // Reading all three values thaws the freeze left by the fraction reads
      vals(ev);
      // Plus 2 and plus 1 degree corrections written as one sum
      wr(`RDT_IDX_R1_OFS, 8'h06);
      o1 = 6;
      wr(`RDT_IDX_R2_OFS, 8'h80);
      o2 = -128;
      rc(`RDT_IDX_R1_OFS, 8'h06);
      rc(`RDT_IDX_R2_OFS, 8'h80);
      wres(1);
      chk(irq, 1'b0);
      wr(`RDT_IDX_MSK, 8'h01);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b1);
      stat(8'h09, 8'h01);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      wr(`RDT_IDX_MSK, 8'h0F);
      frac;
      vals(ev);
      flt <= 1'b1;
      wres(2);
      flt <= 1'b0;
      d1b <= 10'h096;
      d2b <= 10'h0C8;
      wr(`RDT_IDX_CFG5, 8'h02);
      tw = 1;
      chk(irq, 1'b1);
      stat(8'h08, 8'h08);
      frac;
      sv = ev;
      wres(3);
      vals(sv);
      frac;
      vals(ev);
      stat(8'h0C, 8'h04);
      d1b <= 10'h2BC;
      d2b <= 10'h1F4;
      wr(`RDT_IDX_R1_OFS, 8'h7F);
      o1 = 127;
      wres(4);
      frac;
      vals(ev);
      test_done;
   end
endmodule
